/* File: hdl/dac_cmd_params.svh */
// field positions, command codes, reset values and counts of the command decoder
`ifndef DAC_CMD_PARAMS_SVH
`define DAC_CMD_PARAMS_SVH

`define FRAME_W 24
`define RW_BIT 23
`define ZERO_BIT 22
`define TGT_HI 21
`define TGT_LO 19
`define CH_HI 18
`define CH_LO 16
`define RW_WRITE 1'b0

`define TGT_FUNC 3'h0
`define TGT_CODE 3'h2
`define TGT_RANGE 3'h3
`define TGT_GAIN 3'h4
`define TGT_OFFSET 3'h5

`define CH_A 3'h0
`define CH_B 3'h1
`define CH_BOTH 3'h4

`define FN_NOP 3'h0
`define FN_CTRL 3'h1
`define FN_CLEAR 3'h4
`define FN_LOAD 3'h5

`define CTRL_HI 5
`define GAIN_HI 5
`define OFFSET_HI 7
`define RANGE_HI 1

`define NUM_CH 2
`define CLEAR_CODE 16'h0000
`define CODE_RST 16'h0000
`define RANGE_RST 2'h0
`define GAIN_RST 6'h00
`define OFFSET_RST 8'h00
`define CTRL_RST 6'h00

`define CNT_LAST 5'h17
`define CNT_DONE 5'h18
`define SYNC_W 4
`define SYNC_RST 4'h4

`endif

/* File: hdl/dac_cmd_pkg.sv */
// types shared by the command decoder modules
package dac_cmd_pkg;
    typedef logic [15:0] code_t;
    typedef logic [1:0] range_t;
    typedef logic [5:0] gain_t;
    typedef logic [7:0] offset_t;
    typedef logic [2:0] field_t;
    typedef logic [23:0] frame_t;
    // packed from payload bit 5 down to bit 0
    typedef struct packed {
        logic gnd_comp;
        logic dir1;
        logic val1;
        logic dir0;
        logic val0;
        logic sdo_dis;
    } ctrl_word_s;
endpackage

/* File: hdl/frame_link_if.sv */
// carrier between the serial-clock receiver and the core decoder
`timescale 1ns/10ps
interface frame_link_if;
    import dac_cmd_pkg::*;
    frame_t frame;
    logic tog;
    logic sdo_off;
    modport link (output frame, output tog, input sdo_off);
    modport core (input frame, input tog, output sdo_off);
endinterface

/* File: hdl/bit_sync.sv */
// two-flop synchroniser for a group of independent levels
`timescale 1ns/10ps
module bit_sync
    import dac_cmd_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb
    begin
        meta_d = d_i;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_o = sync_q;
endmodule

/* File: hdl/serial_frame_rx.sv */
// serial-clock side: shifts in 24-bit frames and hands each over by toggle
`timescale 1ns/10ps
`include "dac_cmd_params.svh"
module serial_frame_rx
    import dac_cmd_pkg::*;
(
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdin_i,
    input wire logic rst_i,
    output logic sdo_o,
    output logic sdo_oe_n_o,
    frame_link_if.link lnk
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    frame_t shift_q;
    frame_t shift_d;
    frame_t frame_q;
    frame_t frame_d;
    logic tog_q;
    logic tog_d;
    logic off_meta_q;
    logic off_sync_q;

    always_comb
    begin
        cnt_d = cnt_q;
        shift_d = {shift_q[`FRAME_W-2:0], sdin_i};
        frame_d = frame_q;
        tog_d = tog_q;
        if (cnt_q == `CNT_LAST)
        begin
            // word held until the next complete frame, so the core reads it safely
            frame_d = shift_d;
            tog_d = ~tog_q;
            cnt_d = `CNT_DONE;
        end
        else if (cnt_q != `CNT_DONE)
        begin
            cnt_d = cnt_q + 5'h01;
        end
    end

    // frame select high clears the bit count without needing a clock edge
    always_ff @(negedge sclk_i or posedge sync_n_i)
    begin
        if (sync_n_i)
            cnt_q <= 5'h00;
        else
            cnt_q <= cnt_d;
    end

    always_ff @(negedge sclk_i)
    begin
        shift_q <= shift_d;
        frame_q <= frame_d;
    end

    // serial clock may be idle during reset, so these clear without it
    always_ff @(negedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tog_q <= 1'b0;
            off_meta_q <= 1'b0;
            off_sync_q <= 1'b0;
        end
        else
        begin
            tog_q <= tog_d;
            off_meta_q <= lnk.sdo_off;
            off_sync_q <= off_meta_q;
        end
    end

    assign lnk.frame = frame_q;
    assign lnk.tog = tog_q;
    assign sdo_o = shift_q[`FRAME_W-1];
    assign sdo_oe_n_o = off_sync_q;

    a_frame_handover: assert property (@(negedge sclk_i) disable iff (rst_i)
        (cnt_q == `CNT_LAST) |=> (tog_q != $past(tog_q)) && (frame_q == $past(shift_d)))
        else $error("frame not handed over after 24 bits");
endmodule

/* File: hdl/dac_cmd_decode.sv */
// core decoder: frame decode, channel registers, control word and gp pins
`timescale 1ns/10ps
`include "dac_cmd_params.svh"
// Notes on behaviour
// - frame is 24 bits: rw, zero, 3-bit target, 3-bit channel, 16-bit payload
// - target 000 is a function command chosen by channel field
// - function channel 000 does nothing, payload ignored
// - function channel 001 loads control word from payload bits 5..0
// - ground compensation enable follows its bit, cleared at reset
// - direction bit set makes pin output; both inputs after reset
// - output pins drive value bit; input pins report level, writes ignored
// - serial output disable bit turns sdo off; on after reset
// - function channel 100 forces both active codes to the clear code
// - function channel 101 copies buffered codes into active registers
// - target 010 buffers a 16-bit code for addressed channel
// - target 011 stores 2-bit range from bits 1..0
// - range 00 is 10 V span and reset value; 01, 10 wider
// - target 100 stores 6-bit signed gain trim, reset zero
// - gain trim moves both full-scale points by half a step
// - target 101 stores 8-bit signed offset trim, reset zero
module dac_cmd_decode
    import dac_cmd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdin_i,
    output logic sdo_o,
    output logic sdo_oe_n_o,
    input wire logic clear_input_n_i,
    input wire logic gp_pin_0_i,
    output logic gp_pin_0_o,
    output logic gp_pin_0_oe_n_o,
    input wire logic gp_pin_1_i,
    output logic gp_pin_1_o,
    output logic gp_pin_1_oe_n_o,
    output logic gnd_comp_en_o,
    output logic [5:0] ctrl_word_o,
    output logic [15:0] dac_code_a_o,
    output logic [15:0] dac_code_b_o,
    output logic [1:0] range_a_o,
    output logic [1:0] range_b_o,
    output logic [5:0] gain_trim_a_o,
    output logic [5:0] gain_trim_b_o,
    output logic [7:0] offset_trim_a_o,
    output logic [7:0] offset_trim_b_o
);
    frame_link_if lnk ();

    logic [`SYNC_W-1:0] sync_out;
    logic tog_s;
    logic clr_n_s;
    logic pin1_s;
    logic pin0_s;
    logic tog_prev_q;
    logic tog_prev_d;
    logic clr_prev_q;
    logic clr_prev_d;

    logic frame_stb;
    logic is_write;
    field_t target_sel;
    field_t channel_sel;
    code_t payload;
    logic [1:0] ch_mask;
    logic clear_cmd;
    logic load_cmd;
    logic ctrl_cmd;
    logic clear_pin_evt;

    ctrl_word_s ctrl_q;
    ctrl_word_s ctrl_d;
    ctrl_word_s ctrl_new;
    logic [5:0] ctrl_rd_q;
    logic [5:0] ctrl_rd_d;

    code_t code_in_q [`NUM_CH];
    code_t code_act_q [`NUM_CH];
    range_t range_q [`NUM_CH];
    gain_t gain_q [`NUM_CH];
    offset_t offset_q [`NUM_CH];

    // channel field to a per-channel write mask; unused codes address nothing
    function automatic logic [1:0] chan_mask(input field_t ch);
        logic [1:0] m;
        m = 2'h0;
        case (ch)
            `CH_A: m = 2'h1;
            `CH_B: m = 2'h2;
            `CH_BOTH: m = 2'h3;
            default: m = 2'h0;
        endcase
        return m;
    endfunction

    serial_frame_rx u_rx (
        .sclk_i(sclk_i),
        .sync_n_i(sync_n_i),
        .sdin_i(sdin_i),
        .rst_i(rst_i),
        .sdo_o(sdo_o),
        .sdo_oe_n_o(sdo_oe_n_o),
        .lnk(lnk.link)
    );

    bit_sync #(.WIDTH(`SYNC_W), .RST_VAL(`SYNC_RST)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .d_i({lnk.tog, clear_input_n_i, gp_pin_1_i, gp_pin_0_i}),
        .q_o(sync_out)
    );

    assign {tog_s, clr_n_s, pin1_s, pin0_s} = sync_out;

    always_comb
    begin
        tog_prev_d = tog_s;
        clr_prev_d = clr_n_s;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            tog_prev_q <= 1'b0;
            clr_prev_q <= 1'b1;
        end
        else
        begin
            tog_prev_q <= tog_prev_d;
            clr_prev_q <= clr_prev_d;
        end
    end

    // frame word is held stable by the receiver while its toggle is seen here
    always_comb
    begin
        frame_stb = tog_s ^ tog_prev_q;
        is_write = (lnk.frame[`RW_BIT] == `RW_WRITE) && !lnk.frame[`ZERO_BIT];
        target_sel = lnk.frame[`TGT_HI:`TGT_LO];
        channel_sel = lnk.frame[`CH_HI:`CH_LO];
        payload = lnk.frame[15:0];
        ch_mask = (frame_stb && is_write) ? chan_mask(channel_sel) : 2'h0;
        ctrl_cmd = frame_stb && is_write && (target_sel == `TGT_FUNC)
            && (channel_sel == `FN_CTRL);
        clear_cmd = frame_stb && is_write && (target_sel == `TGT_FUNC)
            && (channel_sel == `FN_CLEAR);
        load_cmd = frame_stb && is_write && (target_sel == `TGT_FUNC)
            && (channel_sel == `FN_LOAD);
        clear_pin_evt = clr_prev_q && !clr_n_s;
    end

    // control word; value bits only take a write when the pin is an output
    always_comb
    begin
        ctrl_new = ctrl_word_s'(payload[`CTRL_HI:0]);
        ctrl_d = ctrl_q;
        if (ctrl_cmd)
        begin
            ctrl_d.gnd_comp = ctrl_new.gnd_comp;
            ctrl_d.dir1 = ctrl_new.dir1;
            ctrl_d.dir0 = ctrl_new.dir0;
            ctrl_d.sdo_dis = ctrl_new.sdo_dis;
            if (ctrl_new.dir1)
                ctrl_d.val1 = ctrl_new.val1;
            if (ctrl_new.dir0)
                ctrl_d.val0 = ctrl_new.val0;
        end
        ctrl_rd_d = {ctrl_q.gnd_comp, ctrl_q.dir1, ctrl_q.dir1 ? ctrl_q.val1 : pin1_s,
            ctrl_q.dir0, ctrl_q.dir0 ? ctrl_q.val0 : pin0_s, ctrl_q.sdo_dis};
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= ctrl_word_s'(`CTRL_RST);
            ctrl_rd_q <= `CTRL_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            ctrl_rd_q <= ctrl_rd_d;
        end
    end

    // per-channel storage; nop frames fall through every branch untouched
    for (genvar c = 0; c < `NUM_CH; c++)
    begin : g_ch
        code_t code_in_d;
        code_t code_act_d;
        range_t range_d;
        gain_t gain_d;
        offset_t offset_d;

        always_comb
        begin
            code_in_d = code_in_q[c];
            code_act_d = code_act_q[c];
            range_d = range_q[c];
            gain_d = gain_q[c];
            offset_d = offset_q[c];
            if (ch_mask[c])
            begin
                case (target_sel)
                    `TGT_CODE: code_in_d = payload;
                    `TGT_RANGE: range_d = payload[`RANGE_HI:0];
                    `TGT_GAIN: gain_d = payload[`GAIN_HI:0];
                    `TGT_OFFSET: offset_d = payload[`OFFSET_HI:0];
                    default: code_in_d = code_in_q[c];
                endcase
            end
            // a clear wins over a load arriving in the same cycle
            if (clear_cmd || clear_pin_evt)
                code_act_d = `CLEAR_CODE;
            else if (load_cmd)
                code_act_d = code_in_q[c];
        end

        always_ff @(posedge core_clk_i)
        begin
            if (rst_i)
            begin
                code_in_q[c] <= `CODE_RST;
                code_act_q[c] <= `CODE_RST;
                range_q[c] <= `RANGE_RST;
                gain_q[c] <= `GAIN_RST;
                offset_q[c] <= `OFFSET_RST;
            end
            else
            begin
                code_in_q[c] <= code_in_d;
                code_act_q[c] <= code_act_d;
                range_q[c] <= range_d;
                gain_q[c] <= gain_d;
                offset_q[c] <= offset_d;
            end
        end
    end

    assign lnk.sdo_off = ctrl_q.sdo_dis;
    assign gnd_comp_en_o = ctrl_q.gnd_comp;
    assign gp_pin_0_o = ctrl_q.val0;
    assign gp_pin_1_o = ctrl_q.val1;
    assign gp_pin_0_oe_n_o = ~ctrl_q.dir0;
    assign gp_pin_1_oe_n_o = ~ctrl_q.dir1;
    assign ctrl_word_o = ctrl_rd_q;
    assign dac_code_a_o = code_act_q[0];
    assign dac_code_b_o = code_act_q[1];
    assign range_a_o = range_q[0];
    assign range_b_o = range_q[1];
    // trim applied by the analog side as half a step at each full-scale end
    assign gain_trim_a_o = gain_q[0];
    assign gain_trim_b_o = gain_q[1];
    assign offset_trim_a_o = offset_q[0];
    assign offset_trim_b_o = offset_q[1];

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_func(field_t fn);
        frame_stb && is_write && (target_sel == `TGT_FUNC) && (channel_sel == fn);
    endsequence

    sequence s_store(field_t tgt, field_t ch);
        frame_stb && is_write && (target_sel == tgt) && (channel_sel == ch);
    endsequence

    a_nop_keeps_state: assert property (s_func(`FN_NOP) ##0 !clear_pin_evt |=>
        $stable(ctrl_q) && $stable(code_act_q[0]) && $stable(code_in_q[1])
        && $stable(range_q[0]) && $stable(gain_q[1]) && $stable(offset_q[0]))
        else $error("nop frame changed state");
    a_ctrl_word_load: assert property (s_func(`FN_CTRL) |=>
        ctrl_q.gnd_comp == $past(payload[5]) && ctrl_q.dir1 == $past(payload[4])
        && ctrl_q.dir0 == $past(payload[2]) && ctrl_q.sdo_dis == $past(payload[0]))
        else $error("control word not loaded");
    a_input_val_kept: assert property (s_func(`FN_CTRL) ##0 !payload[2] |=>
        ctrl_q.val0 == $past(ctrl_q.val0))
        else $error("input pin value bit took a write");
    a_pin_output_drive: assert property (s_func(`FN_CTRL) ##0 payload[4] |=>
        !gp_pin_1_oe_n_o && gp_pin_1_o == $past(payload[3]))
        else $error("pin 1 not driven with written value");
    a_sdo_follows: assert property (s_func(`FN_CTRL) |=>
        lnk.sdo_off == $past(payload[0]))
        else $error("serial output disable not applied");
    a_clear_both: assert property (s_func(`FN_CLEAR) |=>
        code_act_q[0] == `CLEAR_CODE && code_act_q[1] == `CLEAR_CODE)
        else $error("clear did not force clear code");
    a_load_copies: assert property (s_func(`FN_LOAD) ##0 !clear_pin_evt |=>
        code_act_q[0] == $past(code_in_q[0]) && code_act_q[1] == $past(code_in_q[1]))
        else $error("load did not copy buffered codes");
    a_code_buffered: assert property (s_store(`TGT_CODE, `CH_B) |=>
        code_in_q[1] == $past(payload) && $stable(code_act_q[1]) || $past(clear_pin_evt))
        else $error("channel b code not buffered");
    a_range_store: assert property (s_store(`TGT_RANGE, `CH_A) |=>
        range_q[0] == $past(payload[1:0]))
        else $error("range code not stored");
    a_gain_store: assert property (s_store(`TGT_GAIN, `CH_BOTH) |=>
        gain_q[0] == $past(payload[5:0]))
        else $error("gain trim not stored");
    a_offset_store: assert property (s_store(`TGT_OFFSET, `CH_BOTH) |=>
        offset_q[1] == $past(payload[7:0]))
        else $error("offset trim not stored");
    a_unaddressed_kept: assert property (frame_stb && is_write && target_sel == `TGT_RANGE
        && chan_mask(channel_sel) == 2'h0 |=> $stable(range_q[0]) && $stable(range_q[1]))
        else $error("unaddressed channel written");
endmodule

/* File: tb/host_serial_model.sv */
// host side of the serial command link: frames sent msb first
`timescale 1ns/10ps
module host_serial_model (
    output logic sclk_o,
    output logic sync_n_o,
    output logic sdin_o
);
    initial
    begin
        sclk_o = 1'b1;
        sdin_o = 1'b0;
        // late update so the receiver sees a rising select and clears its count
        sync_n_o <= 1'b1;
    end

    // sclk parks high between frames; stretch slows the high phase
    task automatic send(input logic [23:0] frame, input int nbits, input int stretch);
        #13 sync_n_o = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            sdin_o = frame[23 - i];
            #(40 + stretch) sclk_o = 1'b0;
            #40 sclk_o = 1'b1;
        end
        #20 sync_n_o = 1'b1;
        // released line: no pull, so show the inverse of the last bit
        sdin_o = ~sdin_o;
    endtask
endmodule

/* File: tb/dac_cmd_decode_tb.sv */
// self-checking bench for the command decoder
`timescale 1ns/10ps
`include "dac_cmd_params.svh"
module dac_cmd_decode_tb;
    import dac_cmd_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i;
    logic clear_input_n_i = 1'b1;
    logic ext0 = 1'b0;
    logic ext1 = 1'b0;
    wire logic sclk;
    wire logic sync_n;
    wire logic sdin;
    wire logic pin0;
    wire logic pin1;
    logic sdo, sdo_oe_n, p0_o, p0_oe_n, p1_o, p1_oe_n, gnd_en;
    logic [5:0] ctrl_w, gain_a, gain_b;
    logic [15:0] code_a, code_b;
    logic [1:0] range_a, range_b;
    logic [7:0] offs_a, offs_b;
    int n_fail = 0;
    int tests_run = 0;

    always #4 core_clk_i = ~core_clk_i;

    // pin level seen by the design: its own drive wins when enabled
    assign pin0 = p0_oe_n ? ext0 : p0_o;
    assign pin1 = p1_oe_n ? ext1 : p1_o;

    host_serial_model u_host_serial_model (
        .sclk_o(sclk),
        .sync_n_o(sync_n),
        .sdin_o(sdin)
    );

    dac_cmd_decode u_dac_cmd_decode (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk), .sync_n_i(sync_n),
        .sdin_i(sdin), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
        .clear_input_n_i(clear_input_n_i),
        .gp_pin_0_i(pin0), .gp_pin_0_o(p0_o), .gp_pin_0_oe_n_o(p0_oe_n),
        .gp_pin_1_i(pin1), .gp_pin_1_o(p1_o), .gp_pin_1_oe_n_o(p1_oe_n),
        .gnd_comp_en_o(gnd_en), .ctrl_word_o(ctrl_w),
        .dac_code_a_o(code_a), .dac_code_b_o(code_b),
        .range_a_o(range_a), .range_b_o(range_b),
        .gain_trim_a_o(gain_a), .gain_trim_b_o(gain_b),
        .offset_trim_a_o(offs_a), .offset_trim_b_o(offs_b)
    );

    task final_report;
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic frame_t fr(input field_t t, input field_t ch, input code_t d);
        return {`RW_WRITE, 1'b0, t, ch, d};
    endfunction

    // core acts 1-2 cycles after the last bit, registers one edge later
    task automatic wr(input frame_t f, input int nbits = 24, input int stretch = 0);
        u_host_serial_model.send(f, nbits, stretch);
        repeat (8) @(posedge core_clk_i);
    endtask

    initial
    begin
        #500000;
        n_fail++;
        final_report();
    end

    initial
    begin
        // a real rising edge, so the link-side flops take their async reset
        rst_i <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chk(code_a, 16'h0000);
        chk(code_b, 16'h0000);
        chk({range_a, range_b, gain_a, gain_b}, 16'h0000);
        chk({offs_a, offs_b}, 16'h0000);
        chk({ctrl_w, gnd_en, p0_oe_n, p1_oe_n, sdo_oe_n}, 16'h0006);
        // buffered code does not reach the output before a load
        wr(fr(`TGT_CODE, `CH_A, 16'h1234));
        chk(code_a, 16'h0000);
        wr(fr(`TGT_CODE, `CH_B, 16'hBEEF), 24, 100);
        wr(fr(`TGT_FUNC, `FN_LOAD, 16'hFFFF));
        chk(code_a, 16'h1234);
        chk(code_b, 16'hBEEF);
        wr(fr(`TGT_CODE, `CH_BOTH, 16'h8001));
        chk(code_a, 16'h1234);
        wr(fr(`TGT_FUNC, `FN_LOAD, 16'h0000));
        chk(code_a, 16'h8001);
        chk(code_b, 16'h8001);
        wr(24'h04A5A5);
        chk(code_a, 16'h0000);
        chk(code_b, 16'h0000);
        wr(fr(`TGT_FUNC, `FN_LOAD, 16'h0000));
        chk(code_b, 16'h8001);
        clear_input_n_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        chk({code_a | code_b}, 16'h0000);
        clear_input_n_i <= 1'b1;
        for (int r = 0; r < 3; r++)
        begin
            wr(fr(`TGT_RANGE, `CH_A, 16'hFFFC | 16'(r)));
            wr(fr(`TGT_RANGE, `CH_B, 16'(2 - r)));
            chk({range_a, range_b}, {12'h000, 2'(r), 2'(2 - r)});
        end
        wr(fr(`TGT_GAIN, `CH_BOTH, 16'hFFE0));
        wr(fr(`TGT_GAIN, `CH_B, 16'h001F));
        chk({gain_a, gain_b}, {4'h0, 6'h20, 6'h1F});
        wr(fr(`TGT_OFFSET, `CH_BOTH, 16'h0080));
        wr(fr(`TGT_OFFSET, `CH_A, 16'hFF7F));
        chk({offs_a, offs_b}, 16'h7F80);
        // refused: read, bit 22 set, short frame, unused channel, no-op
        wr({1'b1, 1'b0, `TGT_RANGE, `CH_A, 16'h0001});
        chk(sdo, 1'b1);
        wr({1'b0, 1'b1, `TGT_RANGE, `CH_A, 16'h0001});
        wr(fr(`TGT_RANGE, `CH_A, 16'h0001), 20);
        wr(fr(`TGT_RANGE, 3'h2, 16'h0001));
        wr(fr(`TGT_FUNC, `FN_NOP, 16'hFFFF));
        chk({range_a, range_b}, 16'h0008);
        chk(code_a, 16'h0000);
        // pin 1 stays input at level 1 while its value bit is written 0
        ext1 <= 1'b1;
        wr(fr(`TGT_FUNC, `FN_CTRL, 16'hFFE5));
        chk({ctrl_w, gnd_en, p0_oe_n, p0_o, p1_oe_n}, 16'h02D9);
        // sdo enable follows only while sclk runs, so clock a no-op
        wr(fr(`TGT_FUNC, `FN_NOP, 16'h0000));
        chk(sdo_oe_n, 1'b1);
        wr(fr(`TGT_FUNC, `FN_CTRL, 16'h0016));
        chk({ctrl_w, gnd_en, p0_oe_n, p0_o, p1_oe_n, p1_o}, 16'h02C4);
        wr(fr(`TGT_FUNC, `FN_NOP, 16'h0000));
        chk(sdo_oe_n, 1'b0);
        final_report();
    end
endmodule
